// [parallel_config_load_port.sv]
`timescale 1ns/1ns
`default_nettype none
module parallel_config_load_port #(
  parameter int unsigned STATUS_LOW_CYC    = cfg_pkg::STATUS_LOW_CYC,
  parameter int unsigned USER_INIT_PERIODS = cfg_pkg::USER_INIT_PERIODS,
  parameter int unsigned POR_DELAY_CYC     = cfg_pkg::POR_DELAY_CYC
)(
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire cfg_pkg::pins_in_s               pins_in,
  output var  cfg_pkg::pins_out_s              pins_out,
  input  wire logic [cfg_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [cfg_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready
);

  localparam int unsigned PIN_W = $bits(cfg_pkg::pins_in_s);

  typedef struct packed {
    cfg_pkg::load_state_e          state;
    logic [cfg_pkg::CNT_W-1:0]     cnt;
    logic [3:0]                    ratio_cnt;
    logic [31:0]                   word_cnt;
    logic [31:0]                   last_word;
    logic                          falls;
    logic                          uclk_on;
    logic                          opt_loaded;
    logic                          init_done_en;
    logic                          clk_prev;
    logic                          uclk_prev;
    logic [31:0]                   ctrl;
    logic [31:0]                   length;
    logic                          aw_got;
    logic                          w_got;
    logic [cfg_pkg::AXI_ADDR_W-1:0] awaddr;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;
    cfg_pkg::pins_out_s            pout;
  } core_s;

  localparam core_s CORE_RESET = '{
    state: cfg_pkg::ST_POR, ctrl: cfg_pkg::CTRL_RESET, length: cfg_pkg::LENGTH_RESET,
    pout: cfg_pkg::POUT_RESET, default: '0};

  core_s             core_ff;
  core_s             nxt_core;
  cfg_pkg::pins_in_s sin;
  logic              clk_rise;
  logic              clk_fall;
  logic              uclk_rise;
  logic [3:0]        ratio;
  logic [31:0]       lane_mask;
  logic [1:0]        width;
  logic              user_clk_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // every pin crosses two flops before anything looks at it
  pin_sync #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pins_in),
    .sync_out (sin)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock-per-word ratio and active data lanes for the chosen bus width
  always_comb
  begin
    width         = core_ff.ctrl[cfg_pkg::CTRL_WIDTH_LSB +: 2];
    user_clk_mode = core_ff.ctrl[cfg_pkg::CTRL_USERCLK_BIT];
    clk_rise      = sin.config_clock & ~core_ff.clk_prev;
    clk_fall      = ~sin.config_clock & core_ff.clk_prev;
    uclk_rise     = sin.user_init_clock & ~core_ff.uclk_prev;
    case (width)
      cfg_pkg::WIDTH_X8:
      begin
        lane_mask = cfg_pkg::MASK_X8; // R9
        ratio     = core_ff.ctrl[cfg_pkg::CTRL_DECOMP_BIT] ? 4'h2 : 4'h1; // R1
      end
      cfg_pkg::WIDTH_X16:
      begin
        lane_mask = cfg_pkg::MASK_X16; // R9
        ratio     = core_ff.ctrl[cfg_pkg::CTRL_DECOMP_BIT] ? 4'h4 :
                    core_ff.ctrl[cfg_pkg::CTRL_SECURE_BIT] ? 4'h2 : 4'h1; // R1
      end
      default:
      begin
        lane_mask = cfg_pkg::MASK_X32; // R9
        ratio     = core_ff.ctrl[cfg_pkg::CTRL_DECOMP_BIT] ? 4'h8 :
                    core_ff.ctrl[cfg_pkg::CTRL_SECURE_BIT] ? 4'h4 : 4'h1; // R1
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // load sequence and register slave, all into one next-state copy
  always_comb
  begin
    nxt_core           = core_ff;
    nxt_core.clk_prev  = sin.config_clock;
    nxt_core.uclk_prev = sin.user_init_clock;

    case (core_ff.state)
      cfg_pkg::ST_POR:
      begin
        nxt_core.cnt = core_ff.cnt + 1'b1;
        if (core_ff.cnt == cfg_pkg::CNT_W'(POR_DELAY_CYC - 1)) // R5
        begin
          nxt_core.state = cfg_pkg::ST_LOADING;
          nxt_core.cnt   = '0;
        end
      end
      cfg_pkg::ST_RESET_HOLD:
      begin
        // request already back high here, since low is caught below
        nxt_core.state = cfg_pkg::ST_STATUS_LOW;
        nxt_core.cnt   = '0;
      end
      cfg_pkg::ST_STATUS_LOW:
      begin
        nxt_core.cnt = core_ff.cnt + 1'b1;
        if (core_ff.cnt == cfg_pkg::CNT_W'(STATUS_LOW_CYC - 1)) // R14
        begin
          nxt_core.state = cfg_pkg::ST_LOADING;
          nxt_core.cnt   = '0;
        end
      end
      cfg_pkg::ST_LOADING:
      begin
        // the first rising edge of each group samples; the rest are spare cycles
        if (clk_rise && core_ff.ratio_cnt == 4'h0) // R16
        begin
          nxt_core.last_word = sin.data & lane_mask; // R9
          nxt_core.word_cnt  = core_ff.word_cnt + 1'b1;
          nxt_core.ratio_cnt = ratio - 4'h1; // R1
          if (!core_ff.opt_loaded)
          begin
            nxt_core.opt_loaded   = 1'b1; // R11
            nxt_core.init_done_en = sin.data[cfg_pkg::OPT_INIT_DONE_BIT];
          end
        end
        else if (clk_rise)
          nxt_core.ratio_cnt = core_ff.ratio_cnt - 4'h1; // R3
        else if (core_ff.word_cnt == core_ff.length && core_ff.word_cnt != 32'h0 &&
                 core_ff.ratio_cnt == 4'h0)
        begin
          nxt_core.state = cfg_pkg::ST_WAIT_FALLS; // R6
          nxt_core.falls = 1'b0;
        end
      end
      cfg_pkg::ST_WAIT_FALLS:
      begin
        if (clk_fall)
        begin
          nxt_core.falls = 1'b1;
          if (core_ff.falls) // R7
          begin
            nxt_core.state   = cfg_pkg::ST_INIT;
            nxt_core.cnt     = '0;
            nxt_core.uclk_on = 1'b0;
          end
        end
      end
      cfg_pkg::ST_INIT:
      begin
        nxt_core.cnt = core_ff.cnt + 1'b1;
        if (!user_clk_mode)
        begin
          if (core_ff.cnt == cfg_pkg::CNT_W'(cfg_pkg::INIT_OSC_CYC - 1)) // R18
            nxt_core.state = cfg_pkg::ST_USER;
        end
        else if (!core_ff.uclk_on)
        begin
          if (core_ff.cnt == cfg_pkg::CNT_W'(cfg_pkg::UCLK_EN_CYC - 1)) // R19
          begin
            nxt_core.uclk_on = 1'b1;
            nxt_core.cnt     = '0;
          end
        end
        else
        begin
          // only user clock edges advance the count once it is enabled
          nxt_core.cnt = core_ff.cnt + {{(cfg_pkg::CNT_W-1){1'b0}}, uclk_rise};
          if (uclk_rise && core_ff.cnt == cfg_pkg::CNT_W'(USER_INIT_PERIODS - 1)) // R19
            nxt_core.state = cfg_pkg::ST_USER;
        end
      end
      cfg_pkg::ST_USER:
      begin
        // config clock is not looked at here
        nxt_core.cnt = '0; // R8
      end
      default:
      begin
        nxt_core.state = cfg_pkg::ST_POR;
        nxt_core.cnt   = '0;
      end
    endcase

    // a request overrides everything but power-on, and throws away partial loads
    if (!sin.reconfig_request_n && core_ff.state != cfg_pkg::ST_POR) // R4
    begin
      nxt_core.state        = cfg_pkg::ST_RESET_HOLD; // R20
      nxt_core.cnt          = '0;
      nxt_core.ratio_cnt    = 4'h0;
      nxt_core.word_cnt     = 32'h0;
      nxt_core.opt_loaded   = 1'b0;
      nxt_core.init_done_en = 1'b0;
    end

    // pin drives follow the next state so they leave the flops together with it
    nxt_core.pout.status_oe_n = !(nxt_core.state inside {cfg_pkg::ST_POR, cfg_pkg::ST_RESET_HOLD,
                                                         cfg_pkg::ST_STATUS_LOW}); // R12
    nxt_core.pout.load_complete_oe_n = nxt_core.state inside {cfg_pkg::ST_WAIT_FALLS,
                                                              cfg_pkg::ST_INIT, cfg_pkg::ST_USER}; // R6
    nxt_core.pout.init_done_oe_n = !(nxt_core.opt_loaded && nxt_core.init_done_en &&
                                     nxt_core.state != cfg_pkg::ST_USER); // R11
    nxt_core.pout.data_user = (nxt_core.state == cfg_pkg::ST_USER &&
                               core_ff.ctrl[cfg_pkg::CTRL_KEEP_IO_BIT]) ? sin.data : 32'h0; // R10

    // write channel: address and data may come in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_core.aw_got = 1'b1;
      nxt_core.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_core.w_got = 1'b1;
      nxt_core.wdata = s_axi_wdata;
      nxt_core.wstrb = s_axi_wstrb;
    end
    if (core_ff.aw_got && core_ff.w_got)
    begin
      nxt_core.aw_got = 1'b0;
      nxt_core.w_got  = 1'b0;
      nxt_core.bvalid = 1'b1;
      nxt_core.bresp  = cfg_pkg::RESP_OKAY;
      for (int b = 0; b < 4; b++)
      begin
        if (core_ff.wstrb[b] && core_ff.awaddr == cfg_pkg::REG_CTRL)
          nxt_core.ctrl[b*8 +: 8] = core_ff.wdata[b*8 +: 8];
        if (core_ff.wstrb[b] && core_ff.awaddr == cfg_pkg::REG_LENGTH)
          nxt_core.length[b*8 +: 8] = core_ff.wdata[b*8 +: 8];
      end
      if (!(core_ff.awaddr inside {cfg_pkg::REG_CTRL, cfg_pkg::REG_LENGTH, cfg_pkg::REG_STATUS,
                                   cfg_pkg::REG_WORDS, cfg_pkg::REG_LAST}))
        nxt_core.bresp = cfg_pkg::RESP_SLVERR;
    end
    if (core_ff.bvalid && s_axi_bready)
      nxt_core.bvalid = 1'b0;

    // read channel: one cycle from address to data
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_core.rvalid = 1'b1;
      nxt_core.rresp  = cfg_pkg::RESP_OKAY;
      nxt_core.rdata  = 32'h0;
      case (s_axi_araddr)
        cfg_pkg::REG_CTRL:   nxt_core.rdata = core_ff.ctrl;
        cfg_pkg::REG_LENGTH: nxt_core.rdata = core_ff.length;
        cfg_pkg::REG_STATUS:
        begin
          nxt_core.rdata[cfg_pkg::STAT_STATE_LSB +: 7] = core_ff.state;
          nxt_core.rdata[cfg_pkg::STAT_STATUS_BIT]     = sin.status_in;
          nxt_core.rdata[cfg_pkg::STAT_LOAD_BIT]       = sin.load_complete_in;
          nxt_core.rdata[cfg_pkg::STAT_INITD_BIT]      = sin.init_done_in;
          nxt_core.rdata[cfg_pkg::STAT_OPT_EN_BIT]     = core_ff.init_done_en;
        end
        cfg_pkg::REG_WORDS:  nxt_core.rdata = core_ff.word_cnt;
        cfg_pkg::REG_LAST:   nxt_core.rdata = core_ff.last_word;
        default:             nxt_core.rresp = cfg_pkg::RESP_SLVERR;
      endcase
    end
    if (core_ff.rvalid && s_axi_rready)
      nxt_core.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      core_ff <= CORE_RESET;
    else
      core_ff <= nxt_core;
  end

  // ready stays low while a response is pending, which keeps one write in flight
  assign s_axi_awready = !core_ff.aw_got && !core_ff.bvalid;
  assign s_axi_wready  = !core_ff.w_got && !core_ff.bvalid;
  assign s_axi_bvalid  = core_ff.bvalid;
  assign s_axi_bresp   = core_ff.bresp;
  assign s_axi_arready = !core_ff.rvalid;
  assign s_axi_rvalid  = core_ff.rvalid;
  assign s_axi_rdata   = core_ff.rdata;
  assign s_axi_rresp   = core_ff.rresp;
  assign pins_out      = core_ff.pout;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_req_pulls_low; // R12
    $fell(sin.reconfig_request_n) && core_ff.state != cfg_pkg::ST_POR |->
      ##[1:2] (pins_out.status_oe_n == 1'b0 && pins_out.load_complete_oe_n == 1'b0);
  endproperty
  a_req_pulls_low: assert property (p_req_pulls_low) else $error("request low not answered");

  property p_por_hold; // R5
    $rose(pins_out.status_oe_n) && $past(core_ff.state) == cfg_pkg::ST_POR |->
      $past(core_ff.cnt) == cfg_pkg::CNT_W'(POR_DELAY_CYC - 1);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("status released before power-on delay");

  property p_status_low_time; // R14
    $rose(pins_out.status_oe_n) && $past(core_ff.state) == cfg_pkg::ST_STATUS_LOW |->
      $past(core_ff.cnt) == cfg_pkg::CNT_W'(STATUS_LOW_CYC - 1);
  endproperty
  a_status_low_time: assert property (p_status_low_time) else $error("status low time wrong");

  property p_load_release; // R6
    $rose(pins_out.load_complete_oe_n) |->
      core_ff.word_cnt == core_ff.length && core_ff.word_cnt != 32'h0;
  endproperty
  a_load_release: assert property (p_load_release) else $error("load flag released early");

  property p_word_step; // R16
    core_ff.state == cfg_pkg::ST_LOADING && sin.reconfig_request_n && clk_rise &&
      core_ff.ratio_cnt == 4'h0 |=>
      core_ff.word_cnt == $past(core_ff.word_cnt) + 32'h1 && core_ff.ratio_cnt == $past(ratio) - 4'h1;
  endproperty
  a_word_step: assert property (p_word_step) else $error("word not taken at ratio boundary");

  property p_lane_mask; // R9
    core_ff.state == cfg_pkg::ST_LOADING && sin.reconfig_request_n && clk_rise &&
      core_ff.ratio_cnt == 4'h0 && width == cfg_pkg::WIDTH_X8 |=> core_ff.last_word[31:8] == 24'h0;
  endproperty
  a_lane_mask: assert property (p_lane_mask) else $error("unused lanes captured");

  property p_init_done_low; // R11
    core_ff.opt_loaded && core_ff.init_done_en && core_ff.state != cfg_pkg::ST_USER |->
      pins_out.init_done_oe_n == 1'b0;
  endproperty
  a_init_done_low: assert property (p_init_done_low) else $error("init-done not driven low");

  property p_osc_init; // R18
    $rose(core_ff.state == cfg_pkg::ST_USER) && !$past(user_clk_mode) |->
      $past(core_ff.cnt) == cfg_pkg::CNT_W'(cfg_pkg::INIT_OSC_CYC - 1);
  endproperty
  a_osc_init: assert property (p_osc_init) else $error("oscillator init length wrong");

  property p_discard; // R20
    !sin.reconfig_request_n && core_ff.state != cfg_pkg::ST_POR |=>
      core_ff.word_cnt == 32'h0 && core_ff.state == cfg_pkg::ST_RESET_HOLD;
  endproperty
  a_discard: assert property (p_discard) else $error("partial load kept under request");

  property p_user_pins; // R4
    core_ff.state == cfg_pkg::ST_USER |->
      pins_out.status_oe_n && pins_out.load_complete_oe_n && pins_out.init_done_oe_n;
  endproperty
  a_user_pins: assert property (p_user_pins) else $error("pin held low in user mode");

  c_user_mode: cover property ($rose(core_ff.state == cfg_pkg::ST_USER));
  c_abort_load: cover property (core_ff.state == cfg_pkg::ST_LOADING && core_ff.word_cnt != 32'h0
                                ##1 core_ff.state == cfg_pkg::ST_RESET_HOLD);
  c_uclk_init: cover property ($rose(core_ff.state == cfg_pkg::ST_USER) && $past(user_clk_mode));

endmodule
`default_nettype wire

// [cfg_pkg.sv]
// Overview of operation
// (R1) cycles per word: 1 with options off, up to 2/4/8 for 8/16/32-bit buses
// (R2) host runs config clock at ratio times its word rate
// (R3) host keeps clocking ratio-1 cycles after the last word is latched
// (R4) user mode: request, status, load flag all high; request low restarts loading
// (R5) status held low for the power-on delay after power-up
// (R6) load flag low from power-up through loading; released only after the full stream
// (R7) host sends whole stream, then two falling clock edges to start initialization
// (R8) config clock ignored after loading; host must not float it
// (R9) 8-bit mode uses data[7:0], 16-bit data[15:0], 32-bit all lines
// (R10) after loading the data lines become user I/O per dual-purpose setting
// (R11) init-done output driven low once its enabling option bit is loaded
// (R12) within 600 ns of request low, load flag and status pulled low
// (R13) host holds request low at least 2 us
// (R14) status low 268 to 1506 us, released within 1506 us of request high
// (R15) host waits 2 us after status high, or 1506 us after request high
// (R16) data sampled on rising clock edge; host holds it N-1 more periods
// (R17) config clock at most 125 MHz (8/16-bit) or 100 MHz (32-bit)
// (R18) oscillator initialization: user mode 175 to 437 us after load flag high
// (R19) user-clock init: enable after 4 max clock periods, user mode after 8576 periods
// (R20) while request low, ignore bus and clock, discard partial configuration
package cfg_pkg;

  localparam int unsigned CLK_MHZ           = 20;
  localparam int unsigned CLK_PERIOD_NS     = 1000 / CLK_MHZ;
  localparam int unsigned CNT_W             = 16;
  // timing figures and their cycle counts
  localparam int unsigned REQ_RESPONSE_NS   = 600;
  localparam int unsigned REQ_RESPONSE_CYC  = REQ_RESPONSE_NS / CLK_PERIOD_NS;
  localparam int unsigned STATUS_LOW_MIN_US = 268;
  localparam int unsigned STATUS_LOW_CYC    = STATUS_LOW_MIN_US * CLK_MHZ;
  localparam int unsigned STATUS_REL_MAX_US = 1506;
  localparam int unsigned STATUS_REL_MAX_CYC = STATUS_REL_MAX_US * CLK_MHZ;
  localparam int unsigned INIT_OSC_MIN_US   = 175;
  localparam int unsigned INIT_OSC_MAX_US   = 437;
  localparam int unsigned INIT_OSC_CYC      = INIT_OSC_MIN_US * CLK_MHZ;
  localparam int unsigned CFG_CLK_MAX_MHZ   = 125;
  localparam int unsigned UCLK_EN_NS        = 4 * 1000 / CFG_CLK_MAX_MHZ;
  localparam int unsigned UCLK_EN_CYC       = (UCLK_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned USER_INIT_PERIODS = 8576;
  localparam int unsigned POR_DELAY_CYC     = 100;

  // register map, byte addresses
  localparam int unsigned AXI_ADDR_W = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_LENGTH = 8'h04;
  localparam logic [7:0]  REG_STATUS = 8'h08;
  localparam logic [7:0]  REG_WORDS  = 8'h0C;
  localparam logic [7:0]  REG_LAST   = 8'h10;
  localparam logic [31:0] CTRL_RESET   = 32'h00000000;
  localparam logic [31:0] LENGTH_RESET = 32'h00000010;
  localparam int unsigned CTRL_WIDTH_LSB   = 0;
  localparam int unsigned CTRL_DECOMP_BIT  = 2;
  localparam int unsigned CTRL_SECURE_BIT  = 3;
  localparam int unsigned CTRL_USERCLK_BIT = 4;
  localparam int unsigned CTRL_KEEP_IO_BIT = 5;
  localparam int unsigned STAT_STATE_LSB   = 0;
  localparam int unsigned STAT_STATUS_BIT  = 8;
  localparam int unsigned STAT_LOAD_BIT    = 9;
  localparam int unsigned STAT_INITD_BIT   = 10;
  localparam int unsigned STAT_OPT_EN_BIT  = 11;
  localparam int unsigned OPT_INIT_DONE_BIT = 0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // bus width codes and lane masks
  localparam logic [1:0]  WIDTH_X8  = 2'h0;
  localparam logic [1:0]  WIDTH_X16 = 2'h1;
  localparam logic [31:0] MASK_X8   = 32'h000000FF;
  localparam logic [31:0] MASK_X16  = 32'h0000FFFF;
  localparam logic [31:0] MASK_X32  = 32'hFFFFFFFF;

  typedef enum logic [6:0] {
    ST_POR        = 7'h01,
    ST_RESET_HOLD = 7'h02,
    ST_STATUS_LOW = 7'h04,
    ST_LOADING    = 7'h08,
    ST_WAIT_FALLS = 7'h10,
    ST_INIT       = 7'h20,
    ST_USER       = 7'h40
  } load_state_e;

  typedef struct packed {
    logic        config_clock;
    logic        reconfig_request_n;
    logic        user_init_clock;
    logic        status_in;
    logic        load_complete_in;
    logic        init_done_in;
    logic [31:0] data;
  } pins_in_s;

  typedef struct packed {
    logic        status_out;
    logic        status_oe_n;
    logic        load_complete_out;
    logic        load_complete_oe_n;
    logic        init_done_out;
    logic        init_done_oe_n;
    logic [31:0] data_user;
  } pins_out_s;

  // status and load flag pulled low from reset, init-done released
  localparam pins_out_s POUT_RESET = '{
    status_out: 1'b0, status_oe_n: 1'b0, load_complete_out: 1'b0, load_complete_oe_n: 1'b0,
    init_done_out: 1'b0, init_done_oe_n: 1'b1, data_user: 32'h00000000};

endpackage

// [pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
)(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s sync_ff;
  sync_s nxt_sync;

  // first stage feeds only the second stage
  always_comb
  begin
    nxt_sync.meta   = async_in;
    nxt_sync.stable = sync_ff.meta;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_ff <= '0;
    else
      sync_ff <= nxt_sync;
  end

  assign sync_out = sync_ff.stable;

endmodule
`default_nettype wire

// [cfg_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
  output var logic        cclk,
  output var logic [31:0] data
);
  // clock rests low between frames
  initial {cclk, data} = 33'h000000000;
  // one 400 ns period, far below the top rate; also used after loading, never floats
  task automatic pulse();
    #200 cclk = 1'b1;
    #200 cclk = 1'b0;
  endtask
  // word held over all n periods of its group; the n-1 spare edges come from this task
  task automatic word(input logic [31:0] d, input int n);
    data = d;
    repeat (n) pulse();
  endtask
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic               aclk, aresetn, req_n, cclk;
  logic [31:0]        cdata, s_axi_wdata, s_axi_rdata;
  logic [7:0]         s_axi_awaddr, s_axi_araddr;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic               s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  cfg_pkg::pins_in_s  pin;
  cfg_pkg::pins_out_s pout;
  int                 error_cnt = 0;
  int                 checks_done = 0;
  longint             t0;
  localparam logic [1:0] OK = cfg_pkg::RESP_OKAY, ERR = cfg_pkg::RESP_SLVERR;
  // open-drain pins read back through their pull-ups; user clock unused here
  assign pin = {cclk, req_n, 1'b0, pout.status_oe_n | pout.status_out,
    pout.load_complete_oe_n | pout.load_complete_out, pout.init_done_oe_n | pout.init_done_out, cdata};
  // short counts so load and reconfiguration fit one run
  parallel_config_load_port #(.STATUS_LOW_CYC(20), .USER_INIT_PERIODS(4), .POR_DELAY_CYC(10)) DUT (
    .aclk, .aresetn, .pins_in(pin), .pins_out(pout), .s_axi_wstrb(4'hF), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  cfg_host_model host (.cclk(cclk), .data(cdata));
  // 20 MHz system clock
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one read or write; valids drop once taken, the wait ends on the answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v, m, input logic [1:0] er);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_bvalid || s_axi_rvalid));
    {s_axi_bready, s_axi_rready} <= 2'h0;
    chk({30'h0, w ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
    if (!w) chk(s_axi_rdata & m, v);
  endtask
  // verdict and end of run
  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // main sequence: power-up, a x16 load with ratio 4, user mode, reconfiguration
  initial
  begin
    aresetn = 1'b0;
    req_n = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(pout.status_oe_n), 32'h0);
    xfer(1'b0, 8'h00, 32'h0, '1, OK);
    xfer(1'b0, 8'h04, 32'h10, '1, OK);
    xfer(1'b0, 8'h14, 32'h0, '1, ERR);
    xfer(1'b1, 8'h14, 32'h0, '1, ERR);
    xfer(1'b1, 8'h00, 32'h25, '1, OK);
    xfer(1'b1, 8'h04, 32'h2, '1, OK);
    xfer(1'b0, 8'h08, 32'h108, 32'h37F, OK);
    // no rising clock edge until status has been high for 2 us
    repeat (40) @(posedge aclk);
    host.word(32'hA5A5A5C3, 4);
    host.word(32'h123456F7, 3);
    repeat (6) @(posedge aclk);
    chk(32'({pout.load_complete_oe_n, pout.init_done_oe_n}), 32'h0);
    host.pulse();
    repeat (6) @(posedge aclk);
    t0 = $time;
    chk(32'(pout.load_complete_oe_n), 32'h1);
    xfer(1'b0, 8'h0C, 32'h2, '1, OK);
    xfer(1'b0, 8'h10, 32'h56F7, '1, OK);
    host.word(32'h5A5A5A5A, 2);
    xfer(1'b0, 8'h08, 32'h20, 32'h7F, OK);
    while (pout.init_done_oe_n !== 1'b1) @(posedge aclk);
    chk(32'(($time - t0) >= 175000 && ($time - t0) <= 437000), 32'h1);
    chk(pout.data_user, cdata);
    chk(32'({pout.status_oe_n, pout.load_complete_oe_n, pout.init_done_oe_n}), 32'h7);
    req_n <= 1'b0;
    repeat (12) @(posedge aclk);
    chk(32'({pout.status_oe_n, pout.load_complete_oe_n}), 32'h0);
    xfer(1'b0, 8'h0C, 32'h0, '1, OK);
    repeat (30) @(posedge aclk);
    req_n <= 1'b1;
    t0 = $time;
    @(posedge aclk);
    while (pout.status_oe_n !== 1'b1) @(posedge aclk);
    chk(32'(($time - t0) >= 1000 && ($time - t0) <= 1506000), 32'h1);
    // byte-wide reload with no options: only the low lane may be stored
    repeat (40) @(posedge aclk);
    xfer(1'b1, 8'h00, 32'h0, '1, OK);
    host.word(32'h1234ABCD, 1);
    repeat (6) @(posedge aclk);
    xfer(1'b0, 8'h10, 32'hCD, '1, OK);
    xfer(1'b0, 8'h0C, 32'h1, '1, OK);
    finish_test();
  end
  // a hang counts as a mismatch; the run needs well under half of this
  initial
  begin
    #2000000;
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire
